// [design/tcr_defines.svh]
// Timing figures and fixed values of the clock and reset generator
`ifndef TCR_DEFINES_SVH
`define TCR_DEFINES_SVH

// Core clock rate
`define TCR_CLK_KHZ          125000
// Main reference input rate
`define TCR_MAIN_KHZ         12000
`define TCR_MAIN_HZ          12000000
// Phase-locked loop output rate
`define TCR_PLL_KHZ          48000
// Ceiling of the high-speed system clock
`define TCR_HS_MAX_KHZ       24000
// Low-speed system clock rate
`define TCR_SLOW_HZ          32768
// Reference ticks before the loop counts as locked
`define TCR_PLL_LOCK_TICKS   64
// Power-on reset hold time in microseconds
`define TCR_POR_US           1000
// Power-on hold as cycles (least time, rounded up)
`define TCR_POR_CYC          ((`TCR_POR_US * `TCR_CLK_KHZ + 999) / 1000)
// Stretch of a device reset after its last request, in ns
`define TCR_RST_STRETCH_NS   1000
`define TCR_RST_STRETCH_CYC  ((`TCR_RST_STRETCH_NS * `TCR_CLK_KHZ + 999999) / 1000000)
// Default fixed-rate prescaler ratios from the main clock
`define TCR_RLC_DIV          12
`define TCR_VOICE_DIV        6
// Default auxiliary divider ratios from the high-speed clock
`define TCR_AUX0_DIV         4
`define TCR_AUX1_DIV         8
// Default prescaler from loop output to high-speed clock
`define TCR_HS_PLL_DIV       2

`endif

// [design/tcr_pkg.sv]
// Types shared by the clock and reset generator
package tcr_pkg;

    // Clock-enable pulses leaving the block
    typedef struct packed {
        logic usb;    // Loop-derived USB clock
        logic rlc;    // Radio link controller clock
        logic voice;  // Voice transcoder clock
        logic aux0;   // First auxiliary pin clock
        logic aux1;   // Second auxiliary pin clock
        logic slow;   // Low-speed system clock
        logic hs;     // High-speed system clock
        logic sys;    // Clock that runs the core now
    } tcr_clk_en_type;

    // Reset requests arriving at the block
    typedef struct packed {
        logic       ext_n;  // External reset pin, active low
        logic       wdog;   // Watchdog trigger
        logic [3:0] mod;    // Other on-chip module requests
    } tcr_rst_req_type;

    // High-speed source switch states
    typedef enum logic [1:0] {
        TCR_SW_RUN      = 2'b00,
        TCR_SW_WAIT_OLD = 2'b01,
        TCR_SW_WAIT_NEW = 2'b10
    } tcr_sw_type;

endpackage : tcr_pkg

// [design/tcr_top.sv]
// Clock and reset generator: clock enables, source switch and device reset
// Functional notes
// - Slow clock from crystal when fitted
// - Otherwise slow clock prescaled from 12 MHz main clock
// - Slow clock runs core in power save
// - Two auxiliary divided clocks onto pins
// - Main clock up to 24 MHz
// - 12 MHz input is loop reference
// - Fixed-rate radio and voice prescaled clocks
// - USB clock comes from loop output
// - High-speed clock: loop prescaled or direct
// - Reset merges external and on-chip requests
// - Main reset with power-on reset
// - Watchdog trigger forces full reset
`timescale 1ns/1ps
`include "tcr_defines.svh"

module tcr_top
    import tcr_pkg::*;
#(
    parameter int POR_CYCLES = `TCR_POR_CYC,      // Power-on hold
    parameter int RLC_DIV    = `TCR_RLC_DIV,      // Radio clock ratio
    parameter int VOICE_DIV  = `TCR_VOICE_DIV,    // Voice clock ratio
    parameter int AUX0_DIV   = `TCR_AUX0_DIV,     // First aux ratio
    parameter int AUX1_DIV   = `TCR_AUX1_DIV,     // Second aux ratio
    parameter int HS_PLL_DIV = `TCR_HS_PLL_DIV    // Loop to fast ratio
) (
    input  wire logic            CLK,
    input  wire logic            RST_N,
    input  wire logic            MAIN_TICK,
    input  wire logic            SLOW_XTAL_TICK,
    input  wire logic            SLOW_XTAL_FITTED,
    input  wire logic            PLL_ENABLE,
    input  wire logic            HS_SEL_PLL,
    input  wire logic            POWER_SAVE,
    input  wire logic [1:0]      AUX_PIN_EN,
    input  wire tcr_rst_req_type RST_REQ,
    output tcr_clk_en_type       CLK_EN,
    output logic                 PLL_LOCKED,
    output logic                 HS_ON_PLL,
    output logic                 DEV_RST_N
);

    // Ratios outside the counters or above the speed ceiling are refused
    // when the block is built, since the divider counters are eight bits
    if (RLC_DIV < 1 || RLC_DIV > 255 || VOICE_DIV < 1 || VOICE_DIV > 255) begin : g_bad_fixed
        $error("tcr_top: fixed-rate ratio out of range");
    end
    if (AUX0_DIV < 1 || AUX0_DIV > 255 || AUX1_DIV < 1 || AUX1_DIV > 255) begin : g_bad_aux
        $error("tcr_top: auxiliary ratio out of range");
    end
    if (HS_PLL_DIV < 1 || HS_PLL_DIV > 255 ||
        `TCR_PLL_KHZ / HS_PLL_DIV > `TCR_HS_MAX_KHZ) begin : g_bad_hs
        $error("tcr_top: high-speed prescaler too small");
    end
    // Reset counter is 24 bits wide
    if (POR_CYCLES < 1 || POR_CYCLES > 16777215) begin : g_bad_por
        $error("tcr_top: power-on hold out of range");
    end

    localparam int NDIV = 5;  // Radio, voice, aux0, aux1, loop prescaler
    localparam int DIVS [NDIV] = '{RLC_DIV, VOICE_DIV, AUX0_DIV, AUX1_DIV, HS_PLL_DIV};

    // Loop model
    // Stands in for the analogue loop as a rate-exact pulse train
    logic [17:0] pll_acc_q;   // Rate accumulator on the core clock
    logic [17:0] pll_acc_d;
    logic [6:0]  lock_cnt_q;  // Reference ticks seen since enable
    logic [6:0]  lock_cnt_d;
    logic        pll_tick;    // Loop output pulse

    // Loop output synthesised from the core clock once locked
    always_comb begin
        pll_tick   = 1'b0;
        pll_acc_d  = pll_acc_q;
        lock_cnt_d = lock_cnt_q;
        if (!PLL_ENABLE) begin
            // Disabled loop loses lock at once
            lock_cnt_d = 7'h00;
            pll_acc_d  = 18'h00000;
        end else begin
            // Lock counts reference edges, so a dead input never locks
            if (MAIN_TICK && lock_cnt_q != 7'(`TCR_PLL_LOCK_TICKS)) begin
                lock_cnt_d = lock_cnt_q + 7'h01;
            end
            if (pll_acc_q + 18'(`TCR_PLL_KHZ) >= 18'(`TCR_CLK_KHZ)) begin
                pll_acc_d = pll_acc_q + 18'(`TCR_PLL_KHZ) - 18'(`TCR_CLK_KHZ);
                pll_tick  = PLL_LOCKED;
            end else begin
                pll_acc_d = pll_acc_q + 18'(`TCR_PLL_KHZ);
            end
        end
    end

    // Loop state registers
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            pll_acc_q  <= 18'h00000;
            lock_cnt_q <= 7'h00;
        end else begin
            pll_acc_q  <= pll_acc_d;
            lock_cnt_q <= lock_cnt_d;
        end
    end

    // Lock drops the cycle after the loop is disabled
    assign PLL_LOCKED = (lock_cnt_q == 7'(`TCR_PLL_LOCK_TICKS));

    // Dividers
    // Eight-bit counters, one per ratio, all on the core clock
    logic [NDIV-1:0] div_src;   // Source pulse per divider
    logic [NDIV-1:0] div_tick;  // Divided pulse per divider
    logic            hs_tick;   // High-speed clock pulse

    // Fixed rates from main; aux from fast clock; prescaler from loop
    assign div_src = {pll_tick, hs_tick, hs_tick, MAIN_TICK, MAIN_TICK};

    for (genvar i = 0; i < NDIV; i++) begin : g_div
        logic [7:0] cnt_q;  // Source pulses within current period
        logic [7:0] cnt_d;
        // Count source pulses, pulse on the last of each period
        always_comb begin
            cnt_d       = cnt_q;
            div_tick[i] = 1'b0;
            if (div_src[i]) begin
                if (cnt_q == 8'(DIVS[i] - 1)) begin
                    cnt_d       = 8'h00;
                    div_tick[i] = 1'b1;
                end else begin
                    cnt_d = cnt_q + 8'h01;
                end
            end
        end
        // Divider count register
        always_ff @(posedge CLK) begin
            if (!RST_N) begin
                cnt_q <= 8'h00;
            end else begin
                cnt_q <= cnt_d;
            end
        end
    end

    // High-speed source switch
    // Both sources are pulse trains, so switching is a pulse-level handover
    tcr_sw_type sw_q;      // Switch state
    tcr_sw_type sw_d;
    logic       sel_q;     // Source in use: 1 means prescaled loop
    logic       sel_d;
    logic       src_tick;  // Pulse of source in use

    // Loop path through prescaler, or main clock directly
    assign src_tick = sel_q ? div_tick[4] : MAIN_TICK;

    // Change only between pulses, dropping the first pulse of the new
    // source so the gap is never shorter than a full new period
    always_comb begin
        sw_d    = sw_q;
        sel_d   = sel_q;
        hs_tick = 1'b0;
        unique case (sw_q)
            TCR_SW_RUN: begin
                hs_tick = src_tick;
                // A switch to the loop starts only while the loop is locked
                if (HS_SEL_PLL != sel_q && (PLL_LOCKED || !HS_SEL_PLL)) begin
                    sw_d = TCR_SW_WAIT_OLD;
                end
            end
            TCR_SW_WAIT_OLD: begin
                hs_tick = src_tick;
                // Stalls if the old source dies; leave the loop before disabling it
                // Leave right after the last old pulse
                if (src_tick) begin
                    sw_d  = TCR_SW_WAIT_NEW;
                    sel_d = ~sel_q;
                end
            end
            TCR_SW_WAIT_NEW: begin
                // First new pulse swallowed, marks a clean period start
                if (src_tick) begin
                    sw_d = TCR_SW_RUN;
                end
            end
            default: begin
                // Illegal code recovers to running on main
                sw_d  = TCR_SW_RUN;
                sel_d = 1'b0;
            end
        endcase
    end

    // Switch registers
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            sw_q  <= TCR_SW_RUN;
            sel_q <= 1'b0;
        end else begin
            sw_q  <= sw_d;
            sel_q <= sel_d;
        end
    end

    assign HS_ON_PLL = sel_q;

    // Slow clock
    // Prescaler runs even with a crystal fitted, ready if it is dropped
    logic [23:0] slow_acc_q;  // Fractional prescaler accumulator
    logic [23:0] slow_acc_d;
    logic        slow_pre;    // Prescaled slow pulse
    logic        slow_tick;   // Chosen slow pulse

    // Fractional ratio keeps the average exact; jitter is one main period
    always_comb begin
        slow_pre   = 1'b0;
        slow_acc_d = slow_acc_q;
        if (MAIN_TICK) begin
            if (slow_acc_q + 24'(`TCR_SLOW_HZ) >= 24'(`TCR_MAIN_HZ)) begin
                slow_acc_d = slow_acc_q + 24'(`TCR_SLOW_HZ) - 24'(`TCR_MAIN_HZ);
                slow_pre   = 1'b1;
            end else begin
                slow_acc_d = slow_acc_q + 24'(`TCR_SLOW_HZ);
            end
        end
    end

    // Slow prescaler register
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            slow_acc_q <= 24'h000000;
        end else begin
            slow_acc_q <= slow_acc_d;
        end
    end

    // Crystal when fitted, prescaler otherwise
    assign slow_tick = SLOW_XTAL_FITTED ? SLOW_XTAL_TICK : slow_pre;

    // Registered clock enables
    // Registering costs one cycle of latency but keeps the outputs clean
    tcr_clk_en_type en_d;  // Next enable pulses

    // Collect all enables; outputs held quiet only while RST_N is low, not during device reset
    always_comb begin
        en_d       = '0;
        en_d.usb   = pll_tick;
        en_d.rlc   = div_tick[0];
        en_d.voice = div_tick[1];
        en_d.aux0  = div_tick[2] & AUX_PIN_EN[0];
        en_d.aux1  = div_tick[3] & AUX_PIN_EN[1];
        en_d.slow  = slow_tick;
        en_d.hs    = hs_tick;
        en_d.sys   = POWER_SAVE ? slow_tick : hs_tick;
    end

    // Enable output registers
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            CLK_EN <= '0;
        end else begin
            CLK_EN <= en_d;
        end
    end

    // Device reset
    // One counter serves both the power-on hold and the request stretch
    logic [23:0] rst_cnt_q;    // Cycles left of device reset
    logic [23:0] rst_cnt_d;
    logic        rst_req;      // Any request active now
    logic        dev_rst_n_d;  // Next device reset level, active low

    // External pin, watchdog and module requests all merge here
    assign rst_req = !RST_REQ.ext_n || RST_REQ.wdog || (|RST_REQ.mod);

    // Hold reset while requested, then stretch so short pulses still act
    always_comb begin
        rst_cnt_d = rst_cnt_q;
        if (rst_req) begin
            if (rst_cnt_q < 24'(`TCR_RST_STRETCH_CYC)) begin
                rst_cnt_d = 24'(`TCR_RST_STRETCH_CYC);
            end
        end else if (rst_cnt_q != 24'h000000) begin
            rst_cnt_d = rst_cnt_q - 24'h000001;
        end
        // Released only once the count is spent and nothing requests
        dev_rst_n_d = (rst_cnt_d == 24'h000000) && !rst_req;
    end

    // Power-up lands here: full power-on hold from the core reset
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            rst_cnt_q <= 24'(POR_CYCLES);
            DEV_RST_N <= 1'b0;
        end else begin
            rst_cnt_q <= rst_cnt_d;
            DEV_RST_N <= dev_rst_n_d;
        end
    end

endmodule : tcr_top

// [test/tb_top.sv]
// Self-checking bench for the clock and reset generator
`timescale 1ns/1ps
module tb_top;
    import tcr_pkg::*;
    localparam int POR = 20; // Short power-on hold
    logic clk, rst_n, fitted, pll_en, sel_pll, psave, slow_run, press, wdog;
    logic [1:0] aux_en;
    logic [3:0] mod;
    logic main_tick, slow_tick, ext_n, locked, on_pll, dev_rst_n;
    tcr_rst_req_type req;
    tcr_clk_en_type en;
    int errors, checked, n, m;
    int cnt[10]; // Enable bits 0..7, main ticks 8, crystal ticks 9
    assign req = {ext_n, wdog, mod};
    tcr_xtal_model u_xtal (.clk(clk), .slow_run(slow_run), .press(press),
        .main_tick(main_tick), .slow_tick(slow_tick), .ext_rst_n(ext_n));
    tcr_top #(.POR_CYCLES(POR)) uut (.CLK(clk), .RST_N(rst_n), .MAIN_TICK(main_tick),
        .SLOW_XTAL_TICK(slow_tick), .SLOW_XTAL_FITTED(fitted), .PLL_ENABLE(pll_en),
        .HS_SEL_PLL(sel_pll), .POWER_SAVE(psave), .AUX_PIN_EN(aux_en), .RST_REQ(req),
        .CLK_EN(en), .PLL_LOCKED(locked), .HS_ON_PLL(on_pll), .DEV_RST_N(dev_rst_n));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Pulse counters, cleared between windows
    always @(posedge clk) begin
        for (int i = 0; i < 8; i++) cnt[i] += en[i];
        cnt[8] += main_tick;
        cnt[9] += slow_tick;
    end
    task automatic near(input int got, input int lo, input int hi);
        checked++;
        if (got < lo || got > hi) begin
            errors++;
            $display("[FAIL] %0t count %0d not in %0d..%0d", $time, got, lo, hi);
        end
    endtask : near
    task automatic meas(input int c);
        @(negedge clk);
        foreach (cnt[i]) cnt[i] = 0;
        repeat (c) @(negedge clk);
    endtask : meas
    function automatic logic sig(input int k);
        case (k)
            0: return locked;
            1: return on_pll;
            default: return dev_rst_n;
        endcase
    endfunction : sig
    // Bounded wait on one status output
    task automatic wait_sig(input int k, input logic v, input int lim, output int c);
        c = 0;
        while (sig(k) !== v) begin
            @(negedge clk);
            c++;
            if (c > lim) begin
                errors++;
                $display("[FAIL] %0t wait %0d timed out", $time, k);
                tally_and_finish();
            end
        end
    endtask : wait_sig
    task automatic t_rates;
        meas(2500);
        m = cnt[8];
        near(cnt[6], m / 12 - 1, m / 12 + 1);
        near(cnt[5], m / 6 - 1, m / 6 + 1);
        near(cnt[1], m - 1, m + 1);
        near(cnt[4], cnt[1] / 4 - 1, cnt[1] / 4 + 1);
        near(cnt[3], cnt[1] / 8 - 1, cnt[1] / 8 + 1);
        near(cnt[7], 0, 0);
        aux_en = 2'h0;
        meas(500);
        near(cnt[4] + cnt[3], 0, 0);
        aux_en = 2'h3;
        $display("t_rates done");
    endtask : t_rates
    task automatic t_slow;
        fitted = 1'b1;
        slow_run = 1'b0;
        meas(8000);
        near(cnt[2], 0, 0);
        slow_run = 1'b1;
        meas(8000);
        near(cnt[2], cnt[9] - 1, cnt[9] + 1);
        fitted = 1'b0;
        slow_run = 1'b0;
        psave = 1'b1;
        meas(8000);
        m = cnt[8] * 32768 / 12000000;
        near(cnt[2], m - 1, m + 1);
        near(cnt[0], cnt[2], cnt[2]);
        psave = 1'b0;
        $display("t_slow done");
    endtask : t_slow
    task automatic t_pll;
        sel_pll = 1'b1;
        pll_en = 1'b1;
        wait_sig(0, 1'b1, 1000, n);
        near(n, 600, 720);
        near((on_pll === 1'b0) ? 0 : 1, 0, 0);
        wait_sig(1, 1'b1, 100, n);
        meas(2500);
        near(cnt[7], 950, 970);
        near(cnt[1], cnt[7] / 2 - 1, cnt[7] / 2 + 1);
        near(cnt[1], 0, 481);
        sel_pll = 1'b0;
        wait_sig(1, 1'b0, 100, n);
        meas(1000);
        // First main pulse after the handover is swallowed inside the window
        near(cnt[1], cnt[8] - 2, cnt[8]);
        $display("t_pll done");
    endtask : t_pll
    task automatic t_reset;
        for (int k = 0; k < 3; k++) begin
            @(negedge clk);
            wdog = (k == 0);
            press = (k == 1);
            mod = (k == 2) ? 4'h8 : 4'h0;
            @(negedge clk);
            near((dev_rst_n === 1'b0) ? 0 : 1, 0, 0);
            wdog = 1'b0;
            press = 1'b0;
            mod = 4'h0;
            wait_sig(2, 1'b1, 200, n);
            near(n, 118, 134);
            repeat (20) @(negedge clk);
            near((dev_rst_n === 1'b1) ? 1 : 0, 1, 1);
        end
        $display("t_reset done");
    endtask : t_reset
    task automatic tally_and_finish;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        {rst_n, fitted, pll_en, sel_pll, psave, press, wdog} = 7'h00;
        {slow_run, aux_en, mod} = 7'h30;
        errors = 0;
        checked = 0;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        wait_sig(2, 1'b1, POR + 10, n);
        near(n, POR - 2, POR + 3);
        t_rates();
        t_slow();
        t_pll();
        t_reset();
        tally_and_finish();
    end
endmodule : tb_top

// [test/tcr_monitor.sv]
// Port checker for the clock and reset generator
`timescale 1ns/1ps
module tcr_monitor
    import tcr_pkg::*;
(
    input wire logic            CLK,
    input wire logic            RST_N,
    input wire logic            MAIN_TICK,
    input wire logic            SLOW_XTAL_TICK,
    input wire logic            SLOW_XTAL_FITTED,
    input wire logic            PLL_ENABLE,
    input wire logic            HS_SEL_PLL,
    input wire logic            POWER_SAVE,
    input wire logic [1:0]      AUX_PIN_EN,
    input wire tcr_rst_req_type RST_REQ,
    input wire tcr_clk_en_type  CLK_EN,
    input wire logic            PLL_LOCKED,
    input wire logic            HS_ON_PLL,
    input wire logic            DEV_RST_N
);
    logic [7:0] quiet_q; // Edges since the last reset request
    logic [7:0] quiet_d; // Next value, saturating
    logic       req;     // Any reset request present
    // Saturation keeps the stretch checks quiet long after a request
    always_comb begin
        req = !RST_REQ.ext_n || RST_REQ.wdog || (|RST_REQ.mod);
        if (!RST_N) quiet_d = 8'hFF;
        else if (req) quiet_d = 8'h00;
        else quiet_d = (quiet_q == 8'hFF) ? quiet_q : quiet_q + 8'h01;
    end
    always_ff @(posedge CLK) quiet_q <= quiet_d;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    a_reset_clears: assert property (disable iff (1'b0)
        !RST_N |=> (CLK_EN == 8'h00 && !DEV_RST_N && !HS_ON_PLL && !PLL_LOCKED))
        else $error("outputs not cleared by reset");
    a_wdog_full_rst: assert property (RST_REQ.wdog |=> !DEV_RST_N)
        else $error("watchdog did not reset device");
    a_req_merge: assert property (req |=> !DEV_RST_N)
        else $error("reset request not merged");
    a_stretch_low: assert property (quiet_q inside {[8'h01:8'h78]} |-> !DEV_RST_N)
        else $error("device reset released too early");
    a_stretch_ends: assert property (quiet_q == 8'h8C |-> DEV_RST_N)
        else $error("device reset held too long");
    a_aux_gated: assert property ((!AUX_PIN_EN[0] |=> !CLK_EN.aux0) and
        (!AUX_PIN_EN[1] |=> !CLK_EN.aux1)) else $error("aux clock not gated");
    a_usb_from_loop: assert property (CLK_EN.usb |-> $past(PLL_LOCKED))
        else $error("usb clock without locked loop");
    a_sys_select: assert property ($stable(POWER_SAVE) |->
        CLK_EN.sys == (POWER_SAVE ? CLK_EN.slow : CLK_EN.hs))
        else $error("core clock source wrong");
    a_switch_target: assert property ($changed(HS_ON_PLL) |->
        HS_ON_PLL == $past(HS_SEL_PLL)) else $error("switched to wrong source");
    // Fast pulses from either source are at least four cycles apart
    a_hs_no_glitch: assert property (CLK_EN.hs |=> (!CLK_EN.hs) [*3])
        else $error("shortened high-speed pulse");
    c_rlc: cover property (CLK_EN.rlc);
    c_to_loop: cover property ($rose(HS_ON_PLL));
    c_dev_rst: cover property ($fell(DEV_RST_N));
    c_to_main: cover property ($fell(HS_ON_PLL));
endmodule : tcr_monitor
bind tcr_top tcr_monitor u_mon (.CLK(CLK), .RST_N(RST_N), .MAIN_TICK(MAIN_TICK),
    .SLOW_XTAL_TICK(SLOW_XTAL_TICK), .SLOW_XTAL_FITTED(SLOW_XTAL_FITTED),
    .PLL_ENABLE(PLL_ENABLE), .HS_SEL_PLL(HS_SEL_PLL), .POWER_SAVE(POWER_SAVE),
    .AUX_PIN_EN(AUX_PIN_EN), .RST_REQ(RST_REQ), .CLK_EN(CLK_EN),
    .PLL_LOCKED(PLL_LOCKED), .HS_ON_PLL(HS_ON_PLL), .DEV_RST_N(DEV_RST_N));

// [test/tcr_xtal_model.sv]
// Crystal networks and reset pin model feeding the generator's tick inputs
`timescale 1ns/1ps
`include "tcr_defines.svh"
module tcr_xtal_model (
    input  wire logic clk,
    input  wire logic slow_run,
    input  wire logic press,
    output logic      main_tick,
    output logic      slow_tick,
    output logic      ext_rst_n
);
    int main_acc = 0; // Main crystal phase, in kHz steps
    int slow_acc = 0; // Slow crystal phase, in Hz steps
    initial main_tick = 1'b0;
    initial slow_tick = 1'b0;
    // Pin pulled up while the button is released
    assign ext_rst_n = !press;
    // Phase accumulators; slow line stands still when the crystal stops
    always @(negedge clk) begin
        main_acc += `TCR_MAIN_KHZ;
        main_tick = (main_acc >= `TCR_CLK_KHZ);
        if (main_tick) main_acc -= `TCR_CLK_KHZ;
        slow_acc += `TCR_SLOW_HZ;
        slow_tick = slow_run && (slow_acc >= `TCR_CLK_KHZ * 1000);
        if (slow_acc >= `TCR_CLK_KHZ * 1000) slow_acc -= `TCR_CLK_KHZ * 1000;
    end
endmodule : tcr_xtal_model
